// *** dbg_addr_map.v ***
// Purpose: debug resource visibility decode
// Assumes: local 16-bit and global 23-bit addresses from the same cycle
// Notes:   purely combinational; registered by the consumer
`timescale 1ns/1ps
`include "dbg_consts.vh"
module dbg_addr_map (
    input  wire        monitor_active,
    input  wire        debug_space_read_cmd,
    input  wire        debug_space_write_cmd,
    input  wire [15:0] local_addr,
    input  wire [22:0] global_addr,
    input  wire [7:0]  program_page_reg,
    output wire        debug_sel,
    output wire        shared_hide
);
    wire hit_high;
    wire hit_paged;
    wire hit_global;
    wire dbg_cycle;

    // Window decode by upper local address byte, global window by global_addr[22:8]
    assign hit_high   = (local_addr[15:8] == `DBG_WIN_HIGH);
    assign hit_paged  = (local_addr[15:8] == `DBG_WIN_PAGED)
                        && (program_page_reg == `DBG_PAGE_BASE);
    assign hit_global = (global_addr[22:8] == `GLOBAL_DBG_PREFIX);
    assign dbg_cycle  = debug_space_read_cmd | debug_space_write_cmd;

    // Outside the monitor, only explicit debug-space cycles select resources
    assign debug_sel = monitor_active ? (hit_high | hit_paged | hit_global)
                                      : dbg_cycle & (hit_high | hit_global);
    // Colliding modules lose their select whenever debug_sel is high
    assign shared_hide = debug_sel;
endmodule

// *** dbg_consts.vh ***
// Purpose: constants for the single-wire debug handshake block
// Assumes: one clock, debug serial clock derived by an enable divider
// Notes:   timing values below are counts of debug serial clock cycles
// Behaviour
// - Acknowledge pulse after handshake-enable command completes
// - Halt command acknowledges on entry to background
// - Resume command acknowledges on leaving background
// - Run-to-halt acknowledges at next background entry
// - Single step: one instruction, re-halt, acknowledge
// - Speed-probe request cancels any pending acknowledge
// - Probe request drops partial command and bit
// - Wait pin high, then 16 cycles
// - Response drives pin low 128 cycles
// - One-cycle high speedup, then release pin
// - Debug resources hidden outside debug access cycles while monitor inactive
// - Active monitor maps resources at 0xFF00-0xFFFF
// - Also at 0xBF00-0xBFFF when page is 0xFF
// - Sharing modules hidden while monitor active; code hides them only while debug_sel is high
// - Special single-chip: monitor controls CPU, no bus
`ifndef DBG_CONSTS_VH
`define DBG_CONSTS_VH
`define PROBE_REQ_CYCLES   8'h80
`define PROBE_GAP_CYCLES   8'h10
`define PROBE_RESP_CYCLES  8'h80
`define ACK_LOW_CYCLES     8'h10
`define DBG_PAGE_BASE      8'hff
`define DBG_WIN_HIGH       8'hff
`define DBG_WIN_PAGED      8'hbf
`define GLOBAL_DBG_PREFIX  15'h7fff
`define CMD_HANDSHAKE_EN   3'h1
`define CMD_HALT           3'h2
`define CMD_RESUME         3'h3
`define CMD_RUN_TO_HALT    3'h4
`define CMD_SINGLE_STEP    3'h5
`endif

// *** dbg_handshake.v ***
// Purpose: single-wire debug pin acknowledge and speed-probe logic
// Assumes: pin input is asynchronous; CPU status inputs share clk
// Notes:   serial clock is clk divided by a parameter
`timescale 1ns/1ps
`include "dbg_consts.vh"
module dbg_handshake #(
    parameter DIV = 8
) (
    input  wire        clk,
    input  wire        reset,
    input  wire        pin_in,
    output reg         pin_out,
    output reg         pin_oe,
    input  wire        cmd_valid,
    input  wire [2:0]  cmd_code,
    input  wire        cpu_in_background,
    input  wire        instr_retired,
    input  wire        special_single_chip,
    input  wire        debug_space_read_cmd,
    input  wire        debug_space_write_cmd,
    input  wire [15:0] local_addr,
    input  wire [22:0] global_addr,
    input  wire [7:0]  program_page_reg,
    output reg         cpu_run_req,
    output reg         cpu_step_req,
    output wire        monitor_active,
    output wire        debug_sel,
    output wire        shared_hide,
    output reg         rx_abort,
    output reg         handshake_on,
    output reg         no_external_bus
);
    localparam S_IDLE = 7'h01;
    localparam S_WHI  = 7'h02;
    localparam S_GAP  = 7'h04;
    localparam S_LOW  = 7'h08;
    localparam S_SPD  = 7'h10;
    localparam S_ALOW = 7'h20;
    localparam S_ASPD = 7'h40;
    localparam W_NONE = 3'h0;
    localparam W_ENTR = 3'h1;
    localparam W_EXIT = 3'h2;

    reg  [6:0]  state;
    reg  [6:0]  next_state;
    reg  [7:0]  cnt;
    reg  [7:0]  low_cnt;
    reg  [15:0] div_cnt;
    reg         pin_s1;
    reg         pin_s2;
    reg         bg_q;
    reg  [2:0]  wait_ev;
    reg         ack_pend;
    wire        tick;
    wire        bg_enter;
    wire        bg_exit;
    wire        probe_seen;

    // Serial clock enable from a divider; keeps one clock domain
    assign tick = (div_cnt == (DIV - 1));
    always @(posedge clk) begin
        if (reset || tick)
            div_cnt <= 16'h0000;
        else
            div_cnt <= div_cnt + 16'h0001;
    end

    // Two-stage synchroniser; only pin_s2 is looked at
    always @(posedge clk) begin
        if (reset) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
        end else begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
        end
    end

    // Measure host low time in serial cycles, saturating
    // Cleared while we drive, else our own response would look like a new request
    always @(posedge clk) begin
        if (reset || pin_s2 || pin_oe)
            low_cnt <= 8'h00;
        else if (tick && low_cnt != 8'hff)
            low_cnt <= low_cnt + 8'h01;
    end
    // Our own drive also pulls low, so only count while released
    assign probe_seen = !pin_oe && low_cnt >= `PROBE_REQ_CYCLES;

    assign bg_enter = cpu_in_background & ~bg_q;
    assign bg_exit  = ~cpu_in_background & bg_q;
    assign monitor_active = cpu_in_background | special_single_chip;

    // Command bookkeeping and CPU control
    always @(posedge clk) begin
        if (reset) begin
            bg_q <= 1'b0;
            wait_ev <= W_NONE;
            ack_pend <= 1'b0;
            handshake_on <= 1'b0;
            cpu_run_req <= 1'b0;
            cpu_step_req <= 1'b0;
            rx_abort <= 1'b0;
            no_external_bus <= 1'b0;
        end else begin
            bg_q <= cpu_in_background;
            rx_abort <= 1'b0;
            cpu_step_req <= 1'b0;
            no_external_bus <= special_single_chip;
            if (state == S_ALOW)
                ack_pend <= 1'b0;
            if (probe_seen && state == S_IDLE) begin
                wait_ev <= W_NONE;
                ack_pend <= 1'b0;
                rx_abort <= 1'b1;
            end else if (cmd_valid) begin
                case (cmd_code)
                    `CMD_HANDSHAKE_EN: begin
                        handshake_on <= 1'b1;
                        ack_pend <= 1'b1;
                    end
                    `CMD_HALT: begin
                        cpu_run_req <= 1'b0;
                        wait_ev <= W_ENTR;
                    end
                    `CMD_RESUME: begin
                        cpu_run_req <= 1'b1;
                        wait_ev <= W_EXIT;
                    end
                    `CMD_RUN_TO_HALT: begin
                        cpu_run_req <= 1'b1;
                        wait_ev <= W_ENTR;
                    end
                    `CMD_SINGLE_STEP: begin
                        cpu_step_req <= 1'b1;
                        wait_ev <= W_ENTR;
                    end
                    default: wait_ev <= wait_ev;
                endcase
            end else begin
                // Retired instruction while stepping with cpu_run_req low: cpu_run_req stays low
                if (instr_retired && wait_ev == W_ENTR && !cpu_run_req)
                    cpu_run_req <= 1'b0;
                if ((wait_ev == W_ENTR && bg_enter) || (wait_ev == W_EXIT && bg_exit)) begin
                    wait_ev <= W_NONE;
                    if (handshake_on)
                        ack_pend <= 1'b1;
                end
                if (bg_enter)
                    cpu_run_req <= 1'b0;
            end
        end
    end

    // Pin sequencer: probe response and acknowledge pulses
    always @* begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (probe_seen)
                    next_state = S_WHI;
                else if (ack_pend && tick && pin_s2)
                    next_state = S_ALOW;
            end
            S_WHI:  if (pin_s2) next_state = S_GAP;
            S_GAP:  if (tick && cnt == `PROBE_GAP_CYCLES - 8'h01) next_state = S_LOW;
            S_LOW:  if (tick && cnt == `PROBE_RESP_CYCLES - 8'h01) next_state = S_SPD;
            S_SPD:  if (tick) next_state = S_IDLE;
            S_ALOW: if (tick && cnt == `ACK_LOW_CYCLES - 8'h01) next_state = S_ASPD;
            S_ASPD: if (tick) next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            state <= S_IDLE;
            cnt <= 8'h00;
        end else begin
            state <= next_state;
            if (next_state != state)
                cnt <= 8'h00;
            else if (tick)
                cnt <= cnt + 8'h01;
        end
    end

    // Registered open-drain drive
    always @(posedge clk) begin
        if (reset) begin
            pin_out <= 1'b1;
            pin_oe <= 1'b0;
        end else begin
            case (next_state)
                S_LOW, S_ALOW: begin
                    pin_out <= 1'b0;
                    pin_oe <= 1'b1;
                end
                S_SPD, S_ASPD: begin
                    pin_out <= 1'b1;
                    pin_oe <= 1'b1;
                end
                default: begin
                    pin_out <= 1'b1;
                    pin_oe <= 1'b0;
                end
            endcase
        end
    end

    dbg_addr_map u_map (
        .monitor_active        (monitor_active),
        .debug_space_read_cmd  (debug_space_read_cmd),
        .debug_space_write_cmd (debug_space_write_cmd),
        .local_addr            (local_addr),
        .global_addr           (global_addr),
        .program_page_reg      (program_page_reg),
        .debug_sel             (debug_sel),
        .shared_hide           (shared_hide)
    );
endmodule

// *** dbg_handshake_chk.sv ***
// Purpose: port assertions for the debug pin handshake block
// Assumes: DIV equals the value given to the design instance
// Notes:   drive phase lengths are counted in clk cycles
`timescale 1ns/1ps
module dbg_handshake_chk #(
    parameter DIV = 8
) (
    input wire        clk,
    input wire        reset,
    input wire        pin_oe,
    input wire        pin_out,
    input wire        rx_abort,
    input wire        cpu_in_background,
    input wire        special_single_chip,
    input wire        monitor_active,
    input wire        debug_sel,
    input wire        shared_hide,
    input wire        debug_space_read_cmd,
    input wire        debug_space_write_cmd,
    input wire [15:0] local_addr,
    input wire [7:0]  program_page_reg,
    input wire        no_external_bus
);
    integer lo_n;
    integer hi_n;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Phase counters, cleared while the pin is released
    always @(posedge clk) begin
        if (reset || !pin_oe) begin
            lo_n <= 0;
            hi_n <= 0;
        end else if (pin_out) begin
            hi_n <= hi_n + 1;
        end else begin
            lo_n <= lo_n + 1;
        end
    end
    sequence s_low_end;
        pin_oe && !pin_out ##1 pin_oe && pin_out;
    endsequence
    chk_low_length: assert property (s_low_end |-> lo_n == 16*DIV || lo_n == 128*DIV)
        else $error("low drive length wrong");
    chk_speedup_len: assert property ($fell(pin_oe) |-> $past(pin_out) && hi_n == DIV)
        else $error("speedup high length wrong");
    chk_abort_pulse: assert property (rx_abort |=> !rx_abort)
        else $error("abort longer than one cycle");
    chk_monitor_on: assert property (monitor_active == (cpu_in_background || special_single_chip))
        else $error("monitor state wrong");
    chk_no_bus: assert property (special_single_chip |=> no_external_bus)
        else $error("external bus not blocked");
    chk_hide_shared: assert property (shared_hide == debug_sel)
        else $error("shared module not hidden");
    chk_hidden_idle: assert property (!monitor_active && !debug_space_read_cmd
        && !debug_space_write_cmd |-> !debug_sel)
        else $error("debug resources visible");
    chk_window_high: assert property (monitor_active && debug_space_read_cmd
        && local_addr[15:8] == 8'hff |-> debug_sel)
        else $error("high window not selected");
    chk_window_paged: assert property (monitor_active && debug_space_read_cmd
        && local_addr[15:8] == 8'hbf && program_page_reg == 8'hff |-> debug_sel)
        else $error("paged window not selected");
endmodule
bind dbg_handshake dbg_handshake_chk #(.DIV(DIV)) chk (.*);

// *** dbg_handshake_test.sv ***
// Purpose: self-checking bench for the debug pin handshake block
// Assumes: DIV of 2, inputs driven on the falling edge
// Notes:   pin level resolved from both open-drain drivers
`timescale 1ns/1ps
module dbg_handshake_test;
    reg clk = 0, reset = 1, cmd_valid = 0, bg = 0, retired = 0, scc = 0, rd = 0, wr = 0, go = 0;
    reg [2:0] cmd_code = 0;
    reg [15:0] local_addr = 0;
    reg [7:0] page = 0;
    wire pin_out, pin_oe, host_oe, host_out, run_req, step_req, mon, sel, hide, rx_abort, hs_on, nobus;
    wire [15:0] host_len;
    integer n_mismatch = 0, compares = 0, gap;
    reg abort_seen = 0;
    // Pull-up: any party driving low wins
    wire pin = !((pin_oe && !pin_out) || (host_oe && !host_out));
    always #4 clk = ~clk;
    always @(posedge clk) if (rx_abort) abort_seen <= 1'b1;
    dbg_host_model #(.LOW(280)) host (.clk(clk), .go(go), .pin(pin), .host_oe(host_oe),
        .host_out(host_out), .resp_len(host_len));
    dbg_handshake #(.DIV(2)) uut (.clk(clk), .reset(reset), .pin_in(pin), .pin_out(pin_out),
        .pin_oe(pin_oe), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cpu_in_background(bg),
        .instr_retired(retired), .special_single_chip(scc), .debug_space_read_cmd(rd),
        .debug_space_write_cmd(wr), .local_addr(local_addr), .global_addr({7'h7f, local_addr}),
        .program_page_reg(page), .cpu_run_req(run_req), .cpu_step_req(step_req),
        .monitor_active(mon), .debug_sel(sel), .shared_hide(hide), .rx_abort(rx_abort),
        .handshake_on(hs_on), .no_external_bus(nobus));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task do_cmd(input [2:0] c);
        cmd_code = c;
        cmd_valid = 1;
        @(negedge clk);
        cmd_valid = 0;
    endtask
    // Find a low drive within bound, then measure it and its speedup
    task pulse(input integer exp_low, input integer bound);
        integer i, lo, hi;
        i = 0;
        lo = 0;
        hi = 0;
        while (i < bound && !(pin_oe === 1 && pin_out === 0)) begin
            @(negedge clk);
            i = i + 1;
        end
        while (lo < 300 && pin_oe === 1 && pin_out === 0) begin
            @(negedge clk);
            lo = lo + 1;
        end
        while (hi < 8 && pin_oe === 1 && pin_out === 1) begin
            @(negedge clk);
            hi = hi + 1;
        end
        check(lo, exp_low);
        if (exp_low != 0) check(hi, 2);
        if (i == bound && exp_low != 0) begin
            n_mismatch = n_mismatch + 1;
            end_of_test;
        end
    endtask
    task probe_cancel;
        bg = 0;
        do_cmd(4);
        go = 1;
        @(negedge clk);
        go = 0;
        gap = 0;
        while (gap < 320 && !(gap > 1 && host_oe === 1'b0)) begin
            @(negedge clk);
            gap = gap + 1;
        end
        if (gap == 320) begin
            n_mismatch = n_mismatch + 1;
            end_of_test;
        end
        gap = 0;
        while (gap < 100 && pin_oe !== 1) begin
            @(negedge clk);
            gap = gap + 1;
        end
        check(abort_seen, 1);
        check(gap >= 32 && gap <= 40, 1);
        pulse(256, 4);
        check(host_len / 128, 2);
        bg = 1;
        pulse(0, 100);
    endtask
    task addr_map;
        rd = 1;
        page = 8'hff;
        local_addr = 16'hff10;
        @(negedge clk);
        check(sel, 1);
        local_addr = 16'hbf10;
        @(negedge clk);
        check(sel, 1);
        page = 8'h00;
        @(negedge clk);
        check({sel, hide}, 2'b00);
        bg = 0;
        rd = 0;
        local_addr = 16'hff10;
        @(negedge clk);
        check({sel, hide}, 2'b00);
        wr = 1;
        @(negedge clk);
        check(sel, 1);
        wr = 0;
        rd = 1;
        @(negedge clk);
        check(sel, 1);
        scc = 1;
        @(negedge clk);
        @(negedge clk);
        check({mon, nobus, hide}, 3'b111);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        reset = 0;
        do_cmd(2);
        bg = 1;
        pulse(0, 100);
        bg = 0;
        do_cmd(1);
        pulse(32, 200);
        check(hs_on, 1);
        do_cmd(2);
        repeat (5) @(negedge clk);
        bg = 1;
        pulse(32, 200);
        do_cmd(3);
        repeat (4) @(negedge clk);
        check(run_req, 1);
        bg = 0;
        pulse(32, 200);
        do_cmd(4);
        pulse(0, 60);
        bg = 1;
        pulse(32, 200);
        do_cmd(5);
        gap = 0;
        while (gap < 20 && step_req !== 1) begin
            @(negedge clk);
            gap = gap + 1;
        end
        check(step_req, 1);
        bg = 0;
        retired = 1;
        @(negedge clk);
        retired = 0;
        bg = 1;
        pulse(32, 200);
        probe_cancel;
        addr_map;
        end_of_test;
    end
endmodule

// *** dbg_host_model.sv ***
// Purpose: external debug host that issues a speed-probe request
// Assumes: driven off the falling clock edge, pin has a pull-up
// Notes:   default low time covers 128 serial cycles only for a DIV of 1 or 2
`timescale 1ns/1ps
module dbg_host_model #(
    parameter LOW = 300
) (
    input  wire        clk,
    input  wire        go,
    input  wire        pin,
    output reg         host_oe,
    output reg         host_out,
    output reg  [15:0] resp_len
);
    integer i;
    initial begin
        host_oe = 1'b0;
        host_out = 1'b1;
        resp_len = 16'h0000;
    end
    // Long low request, short high speedup, then release to the pull-up
    always @(posedge go) begin
        @(negedge clk);
        host_oe = 1'b1;
        host_out = 1'b0;
        repeat (LOW) @(negedge clk);
        host_out = 1'b1;
        @(negedge clk);
        host_oe = 1'b0;
        // Time the target's low response; the bit rate follows from it
        resp_len = 16'h0000;
        for (i = 0; i < 100 && pin; i = i + 1)
            @(negedge clk);
        while (!pin && resp_len < 16'h0400) begin
            @(negedge clk);
            resp_len = resp_len + 16'h0001;
        end
    end
endmodule
